/* File: core/ecg_channel_config.sv */
// ecg channel configuration register bank behind an apb slave, with resync
// command and status registers; drives the applied channel settings.
// assumes master clock select comes from a register on mclk.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// (R1) config changes break record continuity; a resync command restores synchronization
// (R2) rate field resets 10; at 32768 Hz codes give 512, 256, 128 sps
// (R3) at 32000 Hz codes give 500, 250, 125 sps; code 11 reserved
// (R4) clock select 10 or 11 allows only rate code 10: 200 or 199.8 sps
// (R5) gain field resets 00; codes select 20, 40, 80, 160 V/V
// (R6) high-pass bit resets 1; 0 bypasses, 1 gives 0.50 Hz cutoff
// (R7) low-pass field resets 01; 00 decimation only, others about 40/100/150 Hz
// (R8) 100 Hz only at 512/256/500/250 sps; 150 Hz only at 512/500 sps
// (R9) an unsupported low-pass code is applied internally as code 01
// (R10) stored bits are kept, readback shows the effective low-pass code
// (R11) at 128 and 125 sps all filter codes give 28.35 or 27.68 Hz
// (R12) at 200 and 199.8 sps all filter codes give 40.00 or 39.96 Hz
// (R13) new settings reach the channel only after a complete accepted write
module ecg_channel_config #(
  parameter int ADDR_W = ecg_cfg_pkg::ADDR_W
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  // clock family from the general configuration
  input wire logic [1:0] masterClockSel,
  // applied channel settings
  output ecg_cfg_pkg::cfg_t appliedCfg,
  output ecg_cfg_pkg::chan_values_t appliedValues,
  output logic appliedRateReserved,
  output logic appliedLpfRemapped,
  // resync request and pending flag
  output logic resyncPulse,
  output logic changePending
);

  logic pready_q;
  logic [31:0] prdata_q;
  logic [31:0] prdata_d;
  logic pslverr_q;
  logic pslverr_d;
  logic [ecg_cfg_pkg::CFG_W-1:0] cfgWord_q;
  logic [ecg_cfg_pkg::CFG_W-1:0] cfgWord_d;
  logic [ecg_cfg_pkg::CFG_W-1:0] byteMask;
  ecg_cfg_pkg::cfg_t storedCfg;
  ecg_cfg_pkg::cfg_t effCfg;
  ecg_cfg_pkg::cfg_t appliedCfg_q;
  ecg_cfg_pkg::chan_values_t values_d;
  ecg_cfg_pkg::chan_values_t appliedValues_q;
  logic effRateReserved;
  logic effLpfRemapped;
  logic appliedRateReserved_q;
  logic appliedLpfRemapped_q;
  logic [15:0] effRateDeciSps;
  logic [15:0] effLpfCentiHz;
  logic [1:0] mclkSel_q;
  logic resyncPulse_q;
  logic changePending_q;
  logic [ecg_cfg_pkg::CFG_W-1:0] readbackWord;
  logic [31:0] statusWord;
  logic accessCycle;
  logic accept;
  logic hitCfg;
  logic hitResync;
  logic hitStatus;
  logic resyncWrite;
  logic cfgChange;

  // one wait state: pready rises on the second access cycle
  assign accessCycle = psel && penable;
  assign accept = accessCycle && pready_q;
  assign hitCfg = (paddr == ecg_cfg_pkg::CFG_ADDR);
  assign hitResync = (paddr == ecg_cfg_pkg::RESYNC_ADDR);
  assign hitStatus = (paddr == ecg_cfg_pkg::STATUS_ADDR);

  always_ff @(posedge mclk) begin
    if (rst) begin
      pready_q <= 1'b0;
    end else begin
      pready_q <= accessCycle && !pready_q;
    end
  end

  // byte enables for the three low lanes that hold the configuration word
  for (genvar b = 0; b < ecg_cfg_pkg::CFG_W / 8; b++) begin : g_lane
    assign byteMask[b*8 +: 8] = {8{pstrb[b]}};
  end

  always_comb begin
    cfgWord_d = cfgWord_q;
    if (accept && pwrite && hitCfg) begin
      cfgWord_d = (cfgWord_q & ~byteMask) |
                  (pwdata[ecg_cfg_pkg::CFG_W-1:0] & byteMask & ecg_cfg_pkg::CFG_WMASK); // [R13]
    end
  end

  // stored word keeps the field bits exactly as written; bits outside the fields stay zero
  always_ff @(posedge mclk) begin
    if (rst) begin
      cfgWord_q <= '0;
      cfgWord_q[ecg_cfg_pkg::RATE_LSB +: 2] <= ecg_cfg_pkg::RATE_RST; // [R2]
      cfgWord_q[ecg_cfg_pkg::GAIN_LSB +: 2] <= ecg_cfg_pkg::GAIN_RST; // [R5]
      cfgWord_q[ecg_cfg_pkg::HPF_BIT] <= ecg_cfg_pkg::HPF_RST; // [R6]
      cfgWord_q[ecg_cfg_pkg::LPF_LSB +: 2] <= ecg_cfg_pkg::LPF_RST; // [R7]
    end else begin
      cfgWord_q <= cfgWord_d; // [R10]
    end
  end

  assign storedCfg.rate = cfgWord_q[ecg_cfg_pkg::RATE_LSB +: 2];
  assign storedCfg.gain = cfgWord_q[ecg_cfg_pkg::GAIN_LSB +: 2];
  assign storedCfg.hpf = cfgWord_q[ecg_cfg_pkg::HPF_BIT];
  assign storedCfg.lpf = cfgWord_q[ecg_cfg_pkg::LPF_LSB +: 2];

  lowpass_remap u_remap (
    .masterClockSel(masterClockSel),
    .stored(storedCfg),
    .effective(effCfg),
    .rateReserved(effRateReserved),
    .lpfRemapped(effLpfRemapped),
    .rateDeciSps(effRateDeciSps),
    .lpfCentiHz(effLpfCentiHz)
  );

  // decoded values handed to the channel
  always_comb begin
    values_d.rateDeciSps = effRateDeciSps;
    values_d.lpfCentiHz = effLpfCentiHz; // [R7] [R11] [R12]
    values_d.hpfCentiHz = effCfg.hpf ? ecg_cfg_pkg::HPF_CUT_0_50 : 16'h0000; // [R6]
    unique case (effCfg.gain)
      2'h0: values_d.gainVv = ecg_cfg_pkg::GAIN_20; // [R5]
      2'h1: values_d.gainVv = ecg_cfg_pkg::GAIN_40;
      2'h2: values_d.gainVv = ecg_cfg_pkg::GAIN_80;
      2'h3: values_d.gainVv = ecg_cfg_pkg::GAIN_160;
    endcase
  end

  // applied settings follow the stored word one edge after the accept
  always_ff @(posedge mclk) begin
    if (rst) begin
      appliedCfg_q <= '{rate: ecg_cfg_pkg::RATE_RST, gain: ecg_cfg_pkg::GAIN_RST,
                        hpf: ecg_cfg_pkg::HPF_RST, lpf: ecg_cfg_pkg::LPF_RST};
      appliedValues_q <= '0;
      appliedRateReserved_q <= 1'b0;
      appliedLpfRemapped_q <= 1'b0;
      mclkSel_q <= ecg_cfg_pkg::MCLK_32768;
    end else begin
      appliedCfg_q <= effCfg; // [R9] [R13]
      appliedValues_q <= values_d;
      appliedRateReserved_q <= effRateReserved; // [R4]
      appliedLpfRemapped_q <= effLpfRemapped; // [R8]
      mclkSel_q <= masterClockSel;
    end
  end

  // a change of the applied setting, by write or by clock family
  assign cfgChange = (effCfg != appliedCfg_q) || (masterClockSel != mclkSel_q);
  assign resyncWrite = accept && pwrite && hitResync && pstrb[0] &&
                       pwdata[ecg_cfg_pkg::RESYNC_BIT];

  always_ff @(posedge mclk) begin
    if (rst) begin
      resyncPulse_q <= 1'b0;
    end else begin
      resyncPulse_q <= resyncWrite; // [R1]
    end
  end

  // set wins over the clear by a resync command
  always_ff @(posedge mclk) begin
    if (rst) begin
      changePending_q <= 1'b0;
    end else if (cfgChange) begin
      changePending_q <= 1'b1; // [R1]
    end else if (resyncWrite) begin
      changePending_q <= 1'b0;
    end
  end

  // readback shows the effective low-pass code, not the stored one
  always_comb begin
    readbackWord = cfgWord_q;
    readbackWord[ecg_cfg_pkg::LPF_LSB +: 2] = effCfg.lpf; // [R10]
  end

  always_comb begin
    statusWord = '0;
    statusWord[ecg_cfg_pkg::ST_PENDING_BIT] = changePending_q;
    statusWord[ecg_cfg_pkg::ST_RATE_RSVD_BIT] = effRateReserved;
    statusWord[ecg_cfg_pkg::ST_LPF_REMAP_BIT] = effLpfRemapped;
    statusWord[ecg_cfg_pkg::ST_MCLK_LSB +: 2] = masterClockSel;
  end

  // read data and error, presented with pready
  always_comb begin
    prdata_d = '0;
    pslverr_d = 1'b0;
    if (accessCycle && !pready_q) begin
      if (hitCfg) begin
        if (!pwrite) begin
          prdata_d = {{(32 - ecg_cfg_pkg::CFG_W){1'b0}}, readbackWord};
        end
      end else if (hitResync) begin
        prdata_d = '0;
      end else if (hitStatus) begin
        if (pwrite) begin
          pslverr_d = 1'b1;
        end else begin
          prdata_d = statusWord;
        end
      end else begin
        pslverr_d = 1'b1;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      prdata_q <= '0;
      pslverr_q <= 1'b0;
    end else begin
      prdata_q <= prdata_d;
      pslverr_q <= pslverr_d;
    end
  end

  assign pready = pready_q;
  assign prdata = prdata_q;
  assign pslverr = pslverr_q;
  assign appliedCfg = appliedCfg_q;
  assign appliedValues = appliedValues_q;
  assign appliedRateReserved = appliedRateReserved_q;
  assign appliedLpfRemapped = appliedLpfRemapped_q;
  assign resyncPulse = resyncPulse_q;
  assign changePending = changePending_q;

endmodule : ecg_channel_config
`default_nettype wire

/* File: core/ecg_cfg_pkg.sv */
// package for the ecg channel configuration block: register map, fields,
// reset values, code tables and the carrier struct of the channel settings.
// assumes a 32-bit apb bus with one aligned word per register.
package ecg_cfg_pkg;

  // register indices; the byte address is four times the index
  localparam logic [7:0] CFG_INDEX = 8'h15;
  localparam logic [7:0] RESYNC_INDEX = 8'h3a;
  localparam logic [7:0] STATUS_INDEX = 8'h3b;
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] CFG_ADDR = ADDR_W'({CFG_INDEX, 2'b00});
  localparam logic [ADDR_W-1:0] RESYNC_ADDR = ADDR_W'({RESYNC_INDEX, 2'b00});
  localparam logic [ADDR_W-1:0] STATUS_ADDR = ADDR_W'({STATUS_INDEX, 2'b00});

  // configuration word fields
  localparam int CFG_W = 24;
  localparam int RATE_LSB = 22;
  localparam int GAIN_LSB = 16;
  localparam int HPF_BIT = 14;
  localparam int LPF_LSB = 12;
  localparam logic [CFG_W-1:0] CFG_WMASK = 24'hc37000;

  // reset values
  localparam logic [1:0] RATE_RST = 2'h2;
  localparam logic [1:0] GAIN_RST = 2'h0;
  localparam logic HPF_RST = 1'h1;
  localparam logic [1:0] LPF_RST = 2'h1;

  // resync register and status register fields
  localparam int RESYNC_BIT = 0;
  localparam int ST_PENDING_BIT = 0;
  localparam int ST_RATE_RSVD_BIT = 1;
  localparam int ST_LPF_REMAP_BIT = 2;
  localparam int ST_MCLK_LSB = 4;

  // master clock select codes
  localparam logic [1:0] MCLK_32768 = 2'h0;
  localparam logic [1:0] MCLK_32000 = 2'h1;
  localparam logic [1:0] MCLK_32000_FIX = 2'h2;
  localparam logic [1:0] MCLK_31968_FIX = 2'h3;

  // sample rate codes
  localparam logic [1:0] RATE_FAST = 2'h0;
  localparam logic [1:0] RATE_MID = 2'h1;
  localparam logic [1:0] RATE_SLOW = 2'h2;

  // low-pass codes
  localparam logic [1:0] LPF_BYPASS = 2'h0;
  localparam logic [1:0] LPF_40 = 2'h1;
  localparam logic [1:0] LPF_100 = 2'h2;
  localparam logic [1:0] LPF_150 = 2'h3;

  // sample rates in tenths of samples per second
  localparam logic [15:0] SPS_512 = 16'h1400;
  localparam logic [15:0] SPS_256 = 16'h0a00;
  localparam logic [15:0] SPS_128 = 16'h0500;
  localparam logic [15:0] SPS_500 = 16'h1388;
  localparam logic [15:0] SPS_250 = 16'h09c4;
  localparam logic [15:0] SPS_125 = 16'h04e2;
  localparam logic [15:0] SPS_200 = 16'h07d0;
  localparam logic [15:0] SPS_199_8 = 16'h07ce;

  // low-pass cutoffs in hundredths of hertz
  localparam logic [15:0] HZ_40_96 = 16'h1000;
  localparam logic [15:0] HZ_102_4 = 16'h2800;
  localparam logic [15:0] HZ_153_6 = 16'h3c00;
  localparam logic [15:0] HZ_28_35 = 16'h0b13;
  localparam logic [15:0] HZ_40_00 = 16'h0fa0;
  localparam logic [15:0] HZ_100_0 = 16'h2710;
  localparam logic [15:0] HZ_150_0 = 16'h3a98;
  localparam logic [15:0] HZ_27_68 = 16'h0ad0;
  localparam logic [15:0] HZ_39_96 = 16'h0f9c;

  // high-pass cutoff in hundredths of hertz, zero when bypassed
  localparam logic [15:0] HPF_CUT_0_50 = 16'h0032;
  // channel gains in volts per volt
  localparam logic [7:0] GAIN_20 = 8'h14;
  localparam logic [7:0] GAIN_40 = 8'h28;
  localparam logic [7:0] GAIN_80 = 8'h50;
  localparam logic [7:0] GAIN_160 = 8'ha0;

  typedef struct packed {
    logic [1:0] rate;
    logic [1:0] gain;
    logic hpf;
    logic [1:0] lpf;
  } cfg_t;

  typedef struct packed {
    logic [15:0] rateDeciSps;
    logic [15:0] lpfCentiHz;
    logic [15:0] hpfCentiHz;
    logic [7:0] gainVv;
  } chan_values_t;

endpackage : ecg_cfg_pkg

/* File: core/lowpass_remap.sv */
// effective channel setting from the stored word and the master clock select.
// assumes both inputs come from registers on the same clock.
`timescale 1ns/1ps
`default_nettype none
module lowpass_remap (
  // stored settings and clock family
  input wire logic [1:0] masterClockSel,
  input wire ecg_cfg_pkg::cfg_t stored,
  // effective settings
  output ecg_cfg_pkg::cfg_t effective,
  output logic rateReserved,
  output logic lpfRemapped,
  output logic [15:0] rateDeciSps,
  output logic [15:0] lpfCentiHz
);

  typedef enum {CL_FAST, CL_MID, CL_SLOW, CL_FIXED, CL_NONE} rate_class_t;
  rate_class_t rateClass;
  logic lpfOk;

  always_comb begin
    rateClass = CL_NONE;
    rateDeciSps = '0;
    unique case (masterClockSel)
      ecg_cfg_pkg::MCLK_32768: begin
        unique case (stored.rate)
          ecg_cfg_pkg::RATE_FAST: begin
            rateClass = CL_FAST;
            rateDeciSps = ecg_cfg_pkg::SPS_512; // [R2]
          end
          ecg_cfg_pkg::RATE_MID: begin
            rateClass = CL_MID;
            rateDeciSps = ecg_cfg_pkg::SPS_256; // [R2]
          end
          ecg_cfg_pkg::RATE_SLOW: begin
            rateClass = CL_SLOW;
            rateDeciSps = ecg_cfg_pkg::SPS_128; // [R2]
          end
          default: rateClass = CL_NONE;
        endcase
      end
      ecg_cfg_pkg::MCLK_32000: begin
        unique case (stored.rate)
          ecg_cfg_pkg::RATE_FAST: begin
            rateClass = CL_FAST;
            rateDeciSps = ecg_cfg_pkg::SPS_500; // [R3]
          end
          ecg_cfg_pkg::RATE_MID: begin
            rateClass = CL_MID;
            rateDeciSps = ecg_cfg_pkg::SPS_250; // [R3]
          end
          ecg_cfg_pkg::RATE_SLOW: begin
            rateClass = CL_SLOW;
            rateDeciSps = ecg_cfg_pkg::SPS_125; // [R3]
          end
          default: rateClass = CL_NONE;
        endcase
      end
      ecg_cfg_pkg::MCLK_32000_FIX: begin
        if (stored.rate == ecg_cfg_pkg::RATE_SLOW) begin
          rateClass = CL_FIXED;
          rateDeciSps = ecg_cfg_pkg::SPS_200; // [R4]
        end
      end
      ecg_cfg_pkg::MCLK_31968_FIX: begin
        if (stored.rate == ecg_cfg_pkg::RATE_SLOW) begin
          rateClass = CL_FIXED;
          rateDeciSps = ecg_cfg_pkg::SPS_199_8; // [R4]
        end
      end
    endcase
  end

  always_comb begin
    rateReserved = (rateClass == CL_NONE);
    unique case (stored.lpf)
      ecg_cfg_pkg::LPF_100: lpfOk = (rateClass == CL_FAST) || (rateClass == CL_MID); // [R8]
      ecg_cfg_pkg::LPF_150: lpfOk = (rateClass == CL_FAST); // [R8]
      default: lpfOk = 1'b1;
    endcase
    // reserved rates are left alone, no filter table applies to them
    lpfRemapped = !lpfOk && !rateReserved;
    effective = stored;
    if (lpfRemapped) begin
      effective.lpf = ecg_cfg_pkg::LPF_40; // [R9] [R12]
    end
  end

  always_comb begin
    lpfCentiHz = '0;
    if (effective.lpf != ecg_cfg_pkg::LPF_BYPASS && !rateReserved) begin
      unique case (rateClass)
        CL_SLOW: begin
          lpfCentiHz = (masterClockSel == ecg_cfg_pkg::MCLK_32768) ?
            ecg_cfg_pkg::HZ_28_35 : ecg_cfg_pkg::HZ_27_68; // [R11]
        end
        CL_FIXED: begin
          lpfCentiHz = (masterClockSel == ecg_cfg_pkg::MCLK_31968_FIX) ?
            ecg_cfg_pkg::HZ_39_96 : ecg_cfg_pkg::HZ_40_00; // [R12]
        end
        CL_FAST, CL_MID: begin
          if (masterClockSel == ecg_cfg_pkg::MCLK_32768) begin
            unique case (effective.lpf)
              ecg_cfg_pkg::LPF_100: lpfCentiHz = ecg_cfg_pkg::HZ_102_4;
              ecg_cfg_pkg::LPF_150: lpfCentiHz = ecg_cfg_pkg::HZ_153_6;
              default: lpfCentiHz = ecg_cfg_pkg::HZ_40_96;
            endcase
          end else begin
            unique case (effective.lpf)
              ecg_cfg_pkg::LPF_100: lpfCentiHz = ecg_cfg_pkg::HZ_100_0;
              ecg_cfg_pkg::LPF_150: lpfCentiHz = ecg_cfg_pkg::HZ_150_0;
              default: lpfCentiHz = ecg_cfg_pkg::HZ_40_00;
            endcase
          end
        end
        CL_NONE: lpfCentiHz = '0;
      endcase
    end
  end

endmodule : lowpass_remap
`default_nettype wire

/* File: verif/ecg_channel_config_monitor.sv */
// assertions for the ecg channel configuration block, bound to its top module.
// assumes one mclk domain with synchronous active-high rst.
`timescale 1ns/1ps
`default_nettype none
module ecg_channel_config_monitor #(
  parameter int ADDR_W = ecg_cfg_pkg::ADDR_W
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  // channel side
  input wire logic [1:0] masterClockSel,
  input wire ecg_cfg_pkg::cfg_t appliedCfg,
  input wire ecg_cfg_pkg::chan_values_t appliedValues,
  input wire logic appliedRateReserved,
  input wire logic appliedLpfRemapped,
  input wire logic resyncPulse
);
  logic accept;
  logic cfgAcc;
  assign accept = psel && penable && pready && pwrite;
  assign cfgAcc = accept && paddr == ecg_cfg_pkg::CFG_ADDR;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  a_access_wait: assert property (psel && !penable |=> !pready ##1 pready)
    else $error("ready not on second access cycle");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready held longer than one cycle");
  a_cfg_hold: assert property (
    !$past(rst) && !$past(rst, 2) && !$past(cfgAcc) && !$past(cfgAcc, 2) &&
    $stable(masterClockSel) && $past(masterClockSel) == $past(masterClockSel, 2)
    |-> $stable(appliedCfg))
    else $error("applied settings moved without a completed write");
  a_resync_pulse: assert property (
    accept && paddr == ecg_cfg_pkg::RESYNC_ADDR && pwdata[0] |=> resyncPulse ##1 !resyncPulse)
    else $error("resync pulse missing or too long");
  a_remap_lpf: assert property (appliedLpfRemapped |-> appliedCfg.lpf == ecg_cfg_pkg::LPF_40)
    else $error("remapped low-pass code is not the 40 Hz code");
  a_rate_rsvd: assert property (
    !$past(rst) && $past(masterClockSel[1]) && $stable(masterClockSel)
    |-> appliedRateReserved == (appliedCfg.rate != ecg_cfg_pkg::RATE_SLOW))
    else $error("reserved rate flag wrong for fixed clock family");
  a_rsvd_zero: assert property (
    !$past(rst) && appliedRateReserved
    |-> appliedValues.rateDeciSps == 16'h0 && appliedValues.lpfCentiHz == 16'h0)
    else $error("reserved rate still shows a value");
  a_hpf_value: assert property (!$past(rst) |->
    appliedValues.hpfCentiHz == (appliedCfg.hpf ? ecg_cfg_pkg::HPF_CUT_0_50 : 16'h0))
    else $error("high-pass cutoff does not follow its bit");
  a_gain_value: assert property (!$past(rst) |->
    appliedValues.gainVv == 8'(8'h14 << appliedCfg.gain))
    else $error("gain value does not follow gain code");

  c_cfg_write: cover property (cfgAcc);
  c_resync: cover property (resyncPulse);
  c_remap: cover property (appliedLpfRemapped);
endmodule : ecg_channel_config_monitor

bind ecg_channel_config ecg_channel_config_monitor #(.ADDR_W(ADDR_W)) ecg_channel_config_monitor_inst (
  .mclk(mclk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pready(pready), .masterClockSel(masterClockSel), .appliedCfg(appliedCfg),
  .appliedValues(appliedValues), .appliedRateReserved(appliedRateReserved),
  .appliedLpfRemapped(appliedLpfRemapped), .resyncPulse(resyncPulse));
`default_nettype wire

/* File: verif/ecg_channel_config_tb.sv */
// self-checking bench for the ecg channel configuration block over apb.
// assumes one wait state per access and the package register map.
`timescale 1ns/1ps
`default_nettype none
module ecg_channel_config_tb;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'hf;
  logic [1:0] masterClockSel = 2'h0;
  logic pready, pslverr, appliedRateReserved, appliedLpfRemapped, resyncPulse, changePending;
  logic [31:0] prdata;
  ecg_cfg_pkg::cfg_t appliedCfg;
  ecg_cfg_pkg::chan_values_t appliedValues;
  logic [33:0] expQ[$];
  logic [33:0] note;
  int error_cnt = 0;
  int n_compared = 0;
  int seed = 32'h1baf8fa4;

  always #2.5 mclk = ~mclk;

  ecg_channel_config ecg_channel_config_inst (.mclk(mclk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .masterClockSel(masterClockSel),
    .appliedCfg(appliedCfg), .appliedValues(appliedValues),
    .appliedRateReserved(appliedRateReserved), .appliedLpfRemapped(appliedLpfRemapped),
    .resyncPulse(resyncPulse), .changePending(changePending));

  task automatic check(input string what, input logic [55:0] expV, input logic [55:0] gotV);
    n_compared++;
    if (gotV !== expV) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", what, expV, gotV);
    end
  endtask : check

  task automatic results;
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : results

  // one transfer; the note goes to the queue, the watcher compares
  task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] data,
                     input logic err, input logic [31:0] expd);
    int n;
    n = 0;
    expQ.push_back({wr, err, expd});
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= data;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      error_cnt++;
      results();
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask : apb

  always @(posedge mclk) begin
    if (psel && penable && pready === 1'b1 && expQ.size() > 0) begin
      note = expQ.pop_front();
      check("pslverr", 56'(note[32]), 56'(pslverr));
      if (!note[33]) check("prdata", 56'(note[31:0]), 56'(prdata));
    end
  end

  function automatic logic rsvd(input logic [1:0] ms, input logic [1:0] rt);
    return ms[1] ? rt != 2'h2 : rt == 2'h3;
  endfunction : rsvd

  function automatic logic [1:0] effLpf(input logic [1:0] ms, rt, lp);
    if (rsvd(ms, rt)) return lp;
    if (lp == 2'h3 && (ms[1] || rt != 2'h0)) return 2'h1;
    if (lp == 2'h2 && (ms[1] || rt == 2'h2)) return 2'h1;
    return lp;
  endfunction : effLpf

  function automatic logic [15:0] rateOf(input logic [1:0] ms, rt);
    if (rsvd(ms, rt)) return 16'h0;
    if (ms[1]) return ms[0] ? ecg_cfg_pkg::SPS_199_8 : ecg_cfg_pkg::SPS_200;
    return (ms[0] ? ecg_cfg_pkg::SPS_500 : ecg_cfg_pkg::SPS_512) >> rt;
  endfunction : rateOf

  function automatic logic [15:0] cutOf(input logic [1:0] ms, rt, lp);
    if (rsvd(ms, rt) || lp == 2'h0) return 16'h0;
    if (ms[1]) return ms[0] ? ecg_cfg_pkg::HZ_39_96 : ecg_cfg_pkg::HZ_40_00;
    if (rt == 2'h2) return ms[0] ? ecg_cfg_pkg::HZ_27_68 : ecg_cfg_pkg::HZ_28_35;
    case (effLpf(ms, rt, lp))
      2'h1: return ms[0] ? ecg_cfg_pkg::HZ_40_00 : ecg_cfg_pkg::HZ_40_96;
      2'h2: return ms[0] ? ecg_cfg_pkg::HZ_100_0 : ecg_cfg_pkg::HZ_102_4;
      default: return ms[0] ? ecg_cfg_pkg::HZ_150_0 : ecg_cfg_pkg::HZ_153_6;
    endcase
  endfunction : cutOf

  function automatic logic [31:0] rdExp(input logic [1:0] ms, input logic [31:0] w);
    return {8'h0, w[23:22], 4'h0, w[17:16], 1'b0, w[14], effLpf(ms, w[23:22], w[13:12]), 12'h0};
  endfunction : rdExp

  task automatic checkApplied(input logic [1:0] ms, input logic [31:0] w);
    check("appliedCfg", 56'({w[23:22], w[17:16], w[14], effLpf(ms, w[23:22], w[13:12])}),
          56'(appliedCfg));
    check("appliedValues", {rateOf(ms, w[23:22]), cutOf(ms, w[23:22], w[13:12]),
          w[14] ? ecg_cfg_pkg::HPF_CUT_0_50 : 16'h0, 8'h14 << w[17:16]}, appliedValues);
    check("rateReserved", 56'(rsvd(ms, w[23:22])), 56'(appliedRateReserved));
    check("lpfRemapped", 56'(effLpf(ms, w[23:22], w[13:12]) != w[13:12]),
          56'(appliedLpfRemapped));
  endtask : checkApplied

  initial begin : mainSeq
    logic [31:0] w;
    logic [1:0] ms;
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    apb(1'b0, ecg_cfg_pkg::CFG_ADDR, 32'h0, 1'b0, 32'h00805000);
    checkApplied(2'h0, 32'h00805000);
    $display("test reset values done");
    for (int i = 0; i < 64; i++) begin
      ms = i[5:4];
      masterClockSel <= ms;
      w = $random(seed);
      w[23:22] = i[3:2];
      w[13:12] = i[1:0];
      @(posedge mclk);
      apb(1'b1, ecg_cfg_pkg::CFG_ADDR, w, 1'b0, 32'h0);
      apb(1'b0, ecg_cfg_pkg::CFG_ADDR, 32'h0, 1'b0, rdExp(ms, w));
      checkApplied(ms, w);
    end
    $display("test rate and filter table done");
    pstrb <= 4'h0;
    apb(1'b1, ecg_cfg_pkg::CFG_ADDR, ~w, 1'b0, 32'h0);
    pstrb <= 4'hf;
    apb(1'b0, ecg_cfg_pkg::CFG_ADDR, 32'h0, 1'b0, rdExp(ms, w));
    $display("test strobes off done");
    // only the middle lane: high-pass bit and low-pass field cleared
    pstrb <= 4'h2;
    w = w & 32'hffff00ff;
    apb(1'b1, ecg_cfg_pkg::CFG_ADDR, 32'h0, 1'b0, 32'h0);
    pstrb <= 4'hf;
    apb(1'b0, ecg_cfg_pkg::CFG_ADDR, 32'h0, 1'b0, rdExp(ms, w));
    checkApplied(ms, w);
    $display("test partial strobes done");
    apb(1'b0, 8'h10, 32'h0, 1'b1, 32'h0);
    apb(1'b1, ecg_cfg_pkg::STATUS_ADDR, 32'hffffffff, 1'b1, 32'h0);
    $display("test refused accesses done");
    check("changePending", 56'h1, 56'(changePending));
    apb(1'b1, ecg_cfg_pkg::RESYNC_ADDR, 32'h1, 1'b0, 32'h0);
    check("resyncPulse", 56'h1, 56'(resyncPulse));
    apb(1'b0, ecg_cfg_pkg::STATUS_ADDR, 32'h0, 1'b0, 32'h00000032);
    $display("test resync done");
    // reset again in mid-run, with the fixed clock family still selected
    rst <= 1'b1;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    apb(1'b0, ecg_cfg_pkg::CFG_ADDR, 32'h0, 1'b0, 32'h00805000);
    checkApplied(ms, 32'h00805000);
    $display("test reset in run done");
    results();
  end

  initial begin : watchdog
    repeat (5000) @(posedge mclk);
    error_cnt++;
    results();
  end
endmodule : ecg_channel_config_tb
`default_nettype wire
